// *** shared/sup_consts.svh ***
// constants for the supervisor two-wire register access: offsets, fields, resets, timing
// included by both ends and by the bench; holds definitions only
`ifndef SUP_CONSTS_SVH
`define SUP_CONSTS_SVH

`define SUP_ADDR_FAULT       9'h0FF
`define SUP_ADDR_CONTROL     9'h1FF
`define SUP_CTL_WEL_BIT      1
`define SUP_CTL_REGISTER_WRITE_ENABLE_LATCH_BIT     2
`define SUP_CTL_NV_MASK      8'hF9
`define SUP_CTL_RESET        8'h00
`define SUP_FAULT_RESET      8'h00
`define SUP_FAULT_WR_MASK    8'hD8
`define SUP_FAULT_MR_BIT     3
`define SUP_FAULT_WD_BIT     4
`define SUP_FAULT_LV2_BIT    6
`define SUP_FAULT_LV1_BIT    7
`define SUP_CMD_SET_WEL      8'h02
`define SUP_CMD_SET_REGISTER_WRITE_ENABLE_LATCH     8'h06
`define SUP_CMD_CLR_WEL      8'h00
`define SUP_UNMAPPED_DATA    8'hFF
`define SUP_LINK_PERIOD_NS   32
`define SUP_CLK_PERIOD_NS    8
`define SUP_POR_TIMEOUT_NS   200000000
`define SUP_WRITE_CYCLE_NS   5000000
`define SUP_SCL_PERIOD_NS    2500

`endif

// *** shared/sup_pkg.sv ***
// types shared by both ends of the supervisor two-wire link
// uses no macros from sup_consts.svh and does not include it
package sup_pkg;

   typedef enum logic [2:0] {
      DS_IDLE, DS_SLAVE, DS_WORD, DS_DATA, DS_ACK, DS_READ, DS_RACK
   } sup_dev_state_e;

   typedef enum logic [2:0] {OP_START, OP_TX, OP_RX, OP_STOP, OP_DONE} sup_op_e;

   typedef struct packed {
      logic           scl_m, scl_s, scl_p;
      logic           sda_m, sda_s, sda_p;
      logic           wp_m, wp_s;
      logic [3:0]     ev_m, ev_s;
      sup_dev_state_e st;
      sup_dev_state_e after;
      logic [3:0]     bits;
      logic [7:0]     sr;
      logic [8:0]     addr;
      logic [7:0]     pend;
      logic           pend_ok, pend_seen;
      logic           write_enable_latch, register_write_enable_latch;
      logic [7:0]     ctl_nv;
      logic [7:0]     fault;
      logic [31:0]    busy_cnt;
      logic           busy;
      logic [31:0]    por_cnt;
      logic           por_active;
      logic           sda_oe, sda_o;
   } sup_dev_s;

   typedef struct packed {
      logic        sda_m, sda_s;
      logic        rd;
      logic [8:0]  addr;
      logic [7:0]  wdata;
      logic [2:0]  step;
      logic [15:0] div;
      logic [1:0]  ph;
      logic [3:0]  bit_i;
      logic [7:0]  sr;
      logic        scl, sda_oe, sda_o;
      logic        busy, done, nack;
      logic [7:0]  rdata;
   } sup_host_s;

endpackage

// *** shared/sup_twi_if.sv ***
// two-wire link between the bus master and the supervisor register slave
// data line is open drain with a pull-up; level resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface sup_twi_if;
   logic scl;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic sda;

   assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

   modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
   modport dev  (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface
`default_nettype wire

// *** src/sup_twi_device.sv ***
// supervisor register slave: control and fault status registers behind the two-wire link
// runs entirely on the link clock, oversampling scl and sda; other inputs are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "sup_consts.svh"

// Notes on behaviour
// - last slave byte bit one means read
// - random read uses dummy write then restart
// - matching read address acked, byte shifted out
// - master nacks last byte, then stops
// - control at 1FF, fault status at 0FF
// - slave byte: type, two zeros, msb, direction
// - slave address bit is address bit eight
// - address from master or internal counter
// - powers up idle with data released
// - write enable latch clear, control writes blocked
// - reset output held for power-on timeout
// - control writes need write enable latch set
// - write only after full byte before stop
// - control needs two-step unlock sequence
// - write-protect high rejects every write
// - fault status writes need no latch
// - acked read byte continues with next
// - mismatched slave byte not acked
module sup_twi_device
   import sup_pkg::*;
#(
   parameter logic [3:0]  DEV_TYPE   = 4'h6,  // arbitrary identifier value
   parameter int unsigned POR_CYCLES =
      (`SUP_POR_TIMEOUT_NS + `SUP_LINK_PERIOD_NS - 1) / `SUP_LINK_PERIOD_NS,
   parameter int unsigned WR_CYCLES  =
      (`SUP_WRITE_CYCLE_NS + `SUP_LINK_PERIOD_NS - 1) / `SUP_LINK_PERIOD_NS
)(
   input  wire logic       link_clk_in,
   input  wire logic       resetn_in,
   sup_twi_if.dev          bus,
   input  wire logic       wp_in,
   input  wire logic [3:0] fault_event_in,
   output logic [7:0]      control_out,
   output logic [7:0]      fault_status_out,
   output logic            wel_out,
   output logic            busy_out,
   output logic            reset_active_out
);

   localparam sup_dev_s DEV_RESET = '{
      scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
      sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
      st: DS_IDLE, after: DS_IDLE,
      ctl_nv: `SUP_CTL_RESET,
      fault: `SUP_FAULT_RESET,
      por_active: 1'b1,
      default: '0
   };

   localparam int FAULT_POS [4] = '{
      `SUP_FAULT_MR_BIT, `SUP_FAULT_WD_BIT, `SUP_FAULT_LV2_BIT, `SUP_FAULT_LV1_BIT
   };

   sup_dev_s   q;
   sup_dev_s   next_q;
   logic       rise;
   logic       fall;
   logic       start_c;
   logic       stop_c;
   logic [7:0] rdat;

   function automatic logic [7:0] read_byte(input logic [8:0] a, input logic [7:0] nv,
                                            input logic w, input logic rw,
                                            input logic [7:0] f);
      logic [7:0] v;
      v = `SUP_UNMAPPED_DATA;
      if (a == `SUP_ADDR_CONTROL) begin
         v = nv & `SUP_CTL_NV_MASK;
         v[`SUP_CTL_WEL_BIT] = w;
         v[`SUP_CTL_REGISTER_WRITE_ENABLE_LATCH_BIT] = rw;
      end else if (a == `SUP_ADDR_FAULT) begin
         v = f;
      end
      return v;
   endfunction

   always_comb begin
      next_q = q;
      next_q.scl_m = bus.scl;
      next_q.scl_s = q.scl_m;
      next_q.scl_p = q.scl_s;
      next_q.sda_m = bus.sda;
      next_q.sda_s = q.sda_m;
      next_q.sda_p = q.sda_s;
      next_q.wp_m = wp_in;
      next_q.wp_s = q.wp_m;
      next_q.ev_m = fault_event_in;
      next_q.ev_s = q.ev_m;
      rise = q.scl_s & ~q.scl_p;
      fall = ~q.scl_s & q.scl_p;
      start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
      stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
      rdat = read_byte(q.addr, q.ctl_nv, q.write_enable_latch, q.register_write_enable_latch, q.fault);

      // power-on reset output timeout
      if (q.por_active) begin
         if (q.por_cnt >= 32'(POR_CYCLES - 1)) begin
            next_q.por_active = 1'b0;
         end else begin
            next_q.por_cnt = q.por_cnt + 32'd1;
         end
      end

      // nonvolatile write cycle: slave ignores the bus until it ends
      if (q.busy_cnt != 32'd0) begin
         next_q.busy_cnt = q.busy_cnt - 32'd1;
      end
      next_q.busy = (next_q.busy_cnt != 32'd0);

      if (start_c) begin
         next_q.st = DS_SLAVE;
         next_q.bits = 4'd0;
         next_q.sda_oe = 1'b0;
         next_q.pend_ok = 1'b0;
         next_q.pend_seen = 1'b0;
      end else if (stop_c) begin
         // commit only after a whole data byte and its ack; the stop's own scl rise counts one bit
         if (q.st == DS_DATA && q.bits == 4'd1 && q.pend_ok && !q.wp_s) begin
            if (q.addr == `SUP_ADDR_FAULT) begin
               next_q.fault = q.pend & `SUP_FAULT_WR_MASK;
            end else if (q.addr == `SUP_ADDR_CONTROL) begin
               if (q.register_write_enable_latch) begin
                  if (q.pend != `SUP_CMD_SET_REGISTER_WRITE_ENABLE_LATCH) begin
                     next_q.ctl_nv = q.pend & `SUP_CTL_NV_MASK;
                     next_q.register_write_enable_latch = 1'b0;
                     next_q.busy_cnt = 32'(WR_CYCLES);
                     next_q.busy = 1'b1;
                  end
               end else if (q.pend == `SUP_CMD_SET_WEL) begin
                  next_q.write_enable_latch = 1'b1;
               end else if (q.write_enable_latch && q.pend == `SUP_CMD_SET_REGISTER_WRITE_ENABLE_LATCH) begin
                  next_q.register_write_enable_latch = 1'b1;
               end else if (q.pend == `SUP_CMD_CLR_WEL) begin
                  next_q.write_enable_latch = 1'b0;
               end
            end
         end
         next_q.st = DS_IDLE;
         next_q.sda_oe = 1'b0;
      end else if (q.st == DS_SLAVE || q.st == DS_WORD || q.st == DS_DATA) begin
         if (rise && q.bits != 4'd8) begin
            next_q.sr = {q.sr[6:0], q.sda_s};
            next_q.bits = q.bits + 4'd1;
         end else if (fall && q.bits == 4'd8) begin
            next_q.bits = 4'd0;
            next_q.st = DS_ACK;
            next_q.sda_oe = 1'b1;
            unique case (q.st)
               DS_SLAVE: begin
                  if (q.sr[7:4] == DEV_TYPE && q.sr[3:2] == 2'b00 && !q.busy) begin
                     next_q.addr = {q.sr[1], q.addr[7:0]};
                     next_q.after = q.sr[0] ? DS_READ : DS_WORD;
                  end else begin
                     next_q.st = DS_IDLE;
                     next_q.sda_oe = 1'b0;
                  end
               end
               DS_WORD: begin
                  next_q.addr = {q.addr[8], q.sr};
                  next_q.after = DS_DATA;
               end
               DS_DATA: begin
                  next_q.pend = q.sr;
                  next_q.pend_ok = !q.pend_seen;
                  next_q.pend_seen = 1'b1;
                  next_q.after = DS_DATA;
               end
            endcase
         end
      end else if (fall && (q.st == DS_ACK || q.st == DS_RACK)) begin
         if (q.st == DS_ACK && q.after != DS_READ) begin
            next_q.sda_oe = 1'b0;
            next_q.st = q.after;
         end else begin
            next_q.st = DS_READ;
            next_q.sda_oe = ~rdat[7];
            next_q.sr = {rdat[6:0], 1'b0};
            next_q.bits = 4'd1;
         end
      end else if (q.st == DS_RACK && rise && q.sda_s) begin
         next_q.st = DS_IDLE;
      end else if (q.st == DS_READ && fall) begin
         if (q.bits == 4'd8) begin
            next_q.sda_oe = 1'b0;
            next_q.st = DS_RACK;
            next_q.addr = {q.addr[8], q.addr[7:0] + 8'h01};
         end else begin
            next_q.sda_oe = ~q.sr[7];
            next_q.sr = {q.sr[6:0], 1'b0};
            next_q.bits = q.bits + 4'd1;
         end
      end

      // fault events win over a software write in the same cycle
      for (int i = 0; i < 4; i++) begin
         if (q.ev_s[i]) begin
            next_q.fault[FAULT_POS[i]] = 1'b0;
         end
      end
      next_q.sda_o = 1'b0;
   end

   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= DEV_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign bus.dev_sda_oe = q.sda_oe;
   assign bus.dev_sda_out = q.sda_o;
   assign control_out = q.ctl_nv;
   assign fault_status_out = q.fault;
   assign wel_out = q.write_enable_latch;
   assign busy_out = q.busy;
   assign reset_active_out = q.por_active;

endmodule
`default_nettype wire

// *** src/sup_twi_host.sv ***
// bus master for the supervisor registers: single byte write or random read per command
// makes scl from clk_in by a divider; commands come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
`include "sup_consts.svh"

module sup_twi_host
   import sup_pkg::*;
#(
   parameter logic [3:0]  DEV_TYPE       = 4'h6,  // arbitrary identifier value
   parameter int unsigned QUARTER_CYCLES =
      (`SUP_SCL_PERIOD_NS + 4 * `SUP_CLK_PERIOD_NS - 1) / (4 * `SUP_CLK_PERIOD_NS)
)(
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   sup_twi_if.host         bus,
   input  wire logic       cmd_valid_in,
   input  wire logic       cmd_read_in,
   input  wire logic [8:0] cmd_addr_in,
   input  wire logic [7:0] cmd_wdata_in,
   output logic            busy_out,
   output logic            done_out,
   output logic            nack_out,
   output logic [7:0]      rdata_out
);

   localparam sup_host_s HOST_RESET = '{sda_m: 1'b1, sda_s: 1'b1, scl: 1'b1, default: '0};

   sup_host_s  q;
   sup_host_s  next_q;
   sup_op_e    op;
   logic [7:0] txb;

   // write: start, slave, word, data, stop; read: start, slave, word, start, slave, rx, stop
   function automatic sup_op_e op_at(input logic rd, input logic [2:0] step);
      unique case (step)
         3'd0:       op_at = OP_START;
         3'd1, 3'd2: op_at = OP_TX;
         3'd3:       op_at = rd ? OP_START : OP_TX;
         3'd4:       op_at = rd ? OP_TX : OP_STOP;
         3'd5:       op_at = rd ? OP_RX : OP_DONE;
         3'd6:       op_at = rd ? OP_STOP : OP_DONE;
         default:    op_at = OP_DONE;
      endcase
   endfunction

   always_comb begin
      next_q = q;
      next_q.sda_m = bus.sda;
      next_q.sda_s = q.sda_m;
      next_q.done = 1'b0;
      next_q.sda_o = 1'b0;
      op = op_at(q.rd, q.step);
      unique case (q.step)
         3'd1:    txb = {DEV_TYPE, 2'b00, q.addr[8], 1'b0};
         3'd2:    txb = q.addr[7:0];
         3'd3:    txb = q.wdata;
         default: txb = {DEV_TYPE, 2'b00, q.addr[8], 1'b1};
      endcase

      if (!q.busy) begin
         if (cmd_valid_in) begin
            next_q.busy = 1'b1;
            next_q.rd = cmd_read_in;
            next_q.addr = cmd_addr_in;
            next_q.wdata = cmd_wdata_in;
            next_q.step = 3'd0;
            next_q.ph = 2'd0;
            next_q.div = 16'd0;
            next_q.bit_i = 4'd0;
            next_q.nack = 1'b0;
         end
      end else if (q.div != 16'(QUARTER_CYCLES - 1)) begin
         next_q.div = q.div + 16'd1;
      end else begin
         next_q.div = 16'd0;
         next_q.ph = q.ph + 2'd1;
         unique case (op)
            OP_START: begin
               unique case (q.ph)
                  2'd0: begin
                     next_q.scl = 1'b0;
                     next_q.sda_oe = 1'b0;
                  end
                  2'd1: next_q.scl = 1'b1;
                  2'd2: next_q.sda_oe = 1'b1;
                  2'd3: begin
                     next_q.scl = 1'b0;
                     next_q.step = q.step + 3'd1;
                  end
               endcase
            end
            OP_TX, OP_RX: begin
               unique case (q.ph)
                  2'd0: begin
                     next_q.scl = 1'b0;
                     next_q.sda_oe = 1'b0;  // ack slot released; rx nack ends a read
                     if (op == OP_TX && q.bit_i == 4'd0) begin
                        next_q.sr = txb;
                        next_q.sda_oe = ~txb[7];
                     end else if (op == OP_TX && q.bit_i != 4'd8) begin
                        next_q.sda_oe = ~q.sr[7];
                     end else if (op == OP_RX && q.bit_i == 4'd8) begin
                        next_q.rdata = q.sr;
                     end
                  end
                  2'd1: next_q.scl = 1'b1;
                  2'd2: begin
                     if (q.bit_i == 4'd8) begin
                        if (op == OP_TX && q.sda_s) begin
                           next_q.nack = 1'b1;
                        end
                     end else if (op == OP_TX) begin
                        next_q.sr = {q.sr[6:0], 1'b0};
                     end else begin
                        next_q.sr = {q.sr[6:0], q.sda_s};
                     end
                  end
                  2'd3: begin
                     next_q.scl = 1'b0;
                     if (q.bit_i == 4'd8) begin
                        next_q.bit_i = 4'd0;
                        if (q.nack) begin
                           next_q.step = q.rd ? 3'd6 : 3'd4;
                        end else begin
                           next_q.step = q.step + 3'd1;
                        end
                     end else begin
                        next_q.bit_i = q.bit_i + 4'd1;
                     end
                  end
               endcase
            end
            default: begin
               unique case (q.ph)
                  2'd0: begin
                     next_q.scl = 1'b0;
                     next_q.sda_oe = 1'b1;
                  end
                  2'd1: next_q.scl = 1'b1;
                  2'd2: next_q.sda_oe = 1'b0;
                  2'd3: begin
                     next_q.busy = 1'b0;
                     next_q.done = 1'b1;
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= HOST_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign bus.scl = q.scl;
   assign bus.host_sda_oe = q.sda_oe;
   assign bus.host_sda_out = q.sda_o;
   assign busy_out = q.busy;
   assign done_out = q.done;
   assign nack_out = q.nack;
   assign rdata_out = q.rdata;

endmodule
`default_nettype wire

// *** sim/sup_twi_properties.sv ***
// checker for the two-wire link between the bus master and the register slave
// sees only the link signals and both clocks; instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module sup_twi_properties #(
   parameter logic [3:0] DEV_TYPE = 4'h6  // arbitrary identifier value
)(
   input wire logic clk_in,
   input wire logic link_clk_in,
   input wire logic resetn_in,
   input wire logic scl,
   input wire logic host_sda_out,
   input wire logic host_sda_oe,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   logic       ps;
   logic       pd;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [1:0] nst;
   logic       first;
   logic       rdf;
   logic       rise;
   logic       stt;
   logic       stp;
   logic       nine;
   logic       match;
   assign rise  = scl && !ps;
   assign stt   = scl && ps && pd && !sda;
   assign stp   = scl && ps && !pd && sda;
   assign nine  = rise && (cnt == 4'h8);
   assign match = (sh[7:4] == DEV_TYPE) && (sh[3:2] == 2'h0);
   // bit position, slave byte and read phase of the current frame
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ps    <= 1'b1;
         pd    <= 1'b1;
         cnt   <= 4'h0;
         sh    <= 8'h00;
         nst   <= 2'h0;
         first <= 1'b0;
         rdf   <= 1'b0;
      end else begin
         ps <= scl;
         pd <= sda;
         if (stt) begin
            cnt   <= 4'h0;
            first <= 1'b1;
            rdf   <= 1'b0;
            nst   <= nst + 2'h1;
         end else if (stp) begin
            nst   <= 2'h0;
            first <= 1'b0;
            rdf   <= 1'b0;
         end else if (nine) begin
            cnt   <= 4'h0;
            first <= 1'b0;
            if (first) begin
               rdf <= sh[0];
            end
         end else if (rise) begin
            cnt <= cnt + 4'h1;
            sh  <= {sh[6:0], sda};
         end
      end
   end
   a_slave_ack_match: assert property (
      @(posedge clk_in) disable iff (!resetn_in) nine && first |-> sda == !match)
      else $error("slave byte acknowledge wrong");
   a_dir_bit_order: assert property (
      @(posedge clk_in) disable iff (!resetn_in) nine && first |-> sh[0] == (nst == 2'h2))
      else $error("direction bit out of order");
   a_write_bytes_acked: assert property (
      @(posedge clk_in) disable iff (!resetn_in) nine && !first && !rdf |-> !sda)
      else $error("address or data byte not acknowledged");
   a_read_final_nack: assert property (
      @(posedge clk_in) disable iff (!resetn_in) nine && !first && rdf |-> sda ##1 !stt)
      else $error("final read byte acknowledged");
   a_dev_quiet_stop: assert property (
      @(posedge clk_in) disable iff (!resetn_in) stp || stt |-> !dev_sda_oe)
      else $error("slave drives data at start or stop");
   a_dev_stable_high: assert property (
      @(posedge clk_in) disable iff (!resetn_in) scl && ps |-> $stable(dev_sda_oe))
      else $error("slave changes data while clock high");
   a_dev_reset_release: assert property (
      @(posedge link_clk_in) disable iff (!resetn_in) $rose(resetn_in) |-> !dev_sda_oe [*4])
      else $error("slave drives data after reset");
   a_open_drain_low: assert property (
      @(posedge link_clk_in) disable iff (!resetn_in)
      !(dev_sda_oe && dev_sda_out) && !(host_sda_oe && host_sda_out))
      else $error("data line driven high");
   c_read_ack: cover property (@(posedge clk_in) disable iff (!resetn_in)
      nine && first && sh[0] && !sda);
   c_read_nack: cover property (@(posedge clk_in) disable iff (!resetn_in) nine && rdf);
   c_stop: cover property (@(posedge clk_in) disable iff (!resetn_in) stp);
endmodule
`default_nettype wire

// *** sim/supervisor_two_wire_register_access_tb_top.sv ***
// self-checking bench: bus master and register slave joined by the two-wire link
// a second pair with a foreign identifier checks refusal of the slave byte
`timescale 1ns/1ps
`default_nettype none
`include "sup_consts.svh"
module supervisor_two_wire_register_access_tb_top;
   logic        clk_in;
   logic        link_clk;
   logic        resetn;
   logic        cmd_valid;
   logic        cmd_valid_b;
   logic        cmd_read;
   logic [8:0]  cmd_addr;
   logic [7:0]  cmd_wdata;
   logic        busy, done, nack, busy_b, done_b, nack_b;
   logic [7:0]  rdata;
   logic        wp;
   logic [3:0]  fault_ev;
   logic [7:0]  control, fault;
   logic        write_enable_latch, dbusy, rst_act;
   int          fail_count, total_checks;
   logic [31:0] seed;
   logic [7:0]  d, fexp;
   sup_twi_if ifc();
   sup_twi_if ifc_b();
   sup_twi_host #(.QUARTER_CYCLES(16)) i_sup_twi_host (.clk_in(clk_in),
      .resetn_in(resetn), .bus(ifc), .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read),
      .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .busy_out(busy), .done_out(done),
      .nack_out(nack), .rdata_out(rdata));
   sup_twi_device #(.POR_CYCLES(20), .WR_CYCLES(20)) i_sup_twi_device (
      .link_clk_in(link_clk), .resetn_in(resetn), .bus(ifc), .wp_in(wp),
      .fault_event_in(fault_ev), .control_out(control), .fault_status_out(fault),
      .wel_out(write_enable_latch), .busy_out(dbusy), .reset_active_out(rst_act));
   sup_twi_host #(.DEV_TYPE(4'h5), .QUARTER_CYCLES(16)) i_sup_twi_host_b (.clk_in(clk_in),
      .resetn_in(resetn), .bus(ifc_b), .cmd_valid_in(cmd_valid_b), .cmd_read_in(cmd_read),
      .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .busy_out(busy_b),
      .done_out(done_b), .nack_out(nack_b), .rdata_out());
   sup_twi_device i_sup_twi_device_b (
      .link_clk_in(link_clk), .resetn_in(resetn), .bus(ifc_b), .wp_in(wp),
      .fault_event_in(fault_ev), .control_out(), .fault_status_out(), .wel_out(),
      .busy_out(), .reset_active_out());
   sup_twi_properties i_sup_twi_properties (.clk_in(clk_in),
      .link_clk_in(link_clk), .resetn_in(resetn), .scl(ifc.scl),
      .host_sda_out(ifc.host_sda_out), .host_sda_oe(ifc.host_sda_oe),
      .dev_sda_out(ifc.dev_sda_out), .dev_sda_oe(ifc.dev_sda_oe), .sda(ifc.sda));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      link_clk = 1'b0;
      #5;
      forever #16 link_clk = ~link_clk;
   end
   function automatic logic [7:0] exp_fault(input logic [7:0] v);
      return v & `SUP_FAULT_WR_MASK;
   endfunction
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one command on the master port, then time for the link side to settle
   task automatic xfer(input int b, input int rd, input logic [8:0] a, input logic [7:0] v);
      int n;
      @(negedge clk_in);
      cmd_read  = rd[0];
      cmd_addr  = a;
      cmd_wdata = v;
      if (b) cmd_valid_b = 1'b1;
      else cmd_valid = 1'b1;
      @(negedge clk_in);
      cmd_valid   = 1'b0;
      cmd_valid_b = 1'b0;
      n = 0;
      while ((b ? done_b : done) !== 1'b1 && n < 6000) begin
         @(negedge clk_in);
         n++;
      end
      chk(n < 6000, 1'b1);
      chk(b ? busy_b : busy, 1'b0);
      repeat (60) @(negedge clk_in);
   endtask
   initial begin
      repeat (100000) @(posedge clk_in);
      fail_count++;
      end_sim();
   end
   initial begin
      seed = 32'h03dede3d;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_valid_b = 1'b0;
      cmd_read = 1'b0;
      cmd_addr = 9'h000;
      cmd_wdata = 8'h00;
      wp = 1'b0;
      fault_ev = 4'h0;
      fail_count = 0;
      total_checks = 0;
      repeat (6) @(negedge clk_in);
      resetn = 1'b1;
      chk(rst_act, 1'b1);
      chk(control, 8'h00);
      chk(write_enable_latch, 1'b0);
      repeat (88) @(negedge clk_in);
      chk(rst_act, 1'b0);
      xfer(0, 1, `SUP_ADDR_FAULT, 8'h00);
      chk(rdata, `SUP_FAULT_RESET);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         if (i == 3) d = 8'hFF;
         fexp = exp_fault(d);
         xfer(0, 0, `SUP_ADDR_FAULT, d);
         chk(fault, fexp);
         xfer(0, 1, `SUP_ADDR_FAULT, 8'h00);
         chk(rdata, fexp);
         chk(nack, 1'b0);
      end
      fault_ev = 4'h1;
      repeat (16) @(negedge clk_in);
      chk(fault, 8'hD0);
      fault_ev = 4'h0;
      d = 8'($random(seed)) | 8'h80;
      xfer(0, 0, `SUP_ADDR_CONTROL, d);
      chk(control, 8'h00);
      chk(write_enable_latch, 1'b0);
      xfer(0, 0, `SUP_ADDR_CONTROL, `SUP_CMD_SET_WEL);
      chk(write_enable_latch, 1'b1);
      xfer(0, 0, `SUP_ADDR_CONTROL, d);
      chk(control, 8'h00);
      xfer(0, 0, `SUP_ADDR_CONTROL, `SUP_CMD_SET_REGISTER_WRITE_ENABLE_LATCH);
      xfer(0, 0, `SUP_ADDR_CONTROL, `SUP_CMD_SET_REGISTER_WRITE_ENABLE_LATCH);
      chk(control, 8'h00);
      xfer(0, 0, `SUP_ADDR_CONTROL, d);
      chk(control, d & `SUP_CTL_NV_MASK);
      chk(dbusy, 1'b1);
      xfer(0, 1, `SUP_ADDR_CONTROL, 8'h00);
      chk(rdata, (d & `SUP_CTL_NV_MASK) | 8'h02);
      xfer(0, 1, `SUP_ADDR_FAULT, 8'h00);
      chk(rdata, 8'hD0);
      xfer(0, 1, 9'h0FE, 8'h00);
      chk(rdata, `SUP_UNMAPPED_DATA);
      xfer(0, 0, `SUP_ADDR_CONTROL, `SUP_CMD_CLR_WEL);
      chk(write_enable_latch, 1'b0);
      wp = 1'b1;
      xfer(0, 0, `SUP_ADDR_CONTROL, `SUP_CMD_SET_WEL);
      chk(write_enable_latch, 1'b0);
      xfer(0, 0, `SUP_ADDR_FAULT, 8'h00);
      chk(fault, 8'hD0);
      wp = 1'b0;
      xfer(1, 1, `SUP_ADDR_FAULT, 8'h00);
      chk(nack_b, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
